/* File: common/aciou_cfg.svh */
// Purpose: Constants for the accumulator and I/O command unit
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes:   Frame layout, opcodes, banks and status codes
// What this block does
// [RULE1] Bank 0 port 0..6 returns input level
// [RULE2] Port 255 bank 0 loads inputs into accumulator
// [RULE3] Bank 1 port 0 returns 16-bit analog
// [RULE4] Analog line readable digitally and analogly, independently
// [RULE5] Bank 2 port 0..7 returns output latch
// [RULE6] Command frame order; input read opcode 0f
// [RULE7] Reply frame order; success status 64 hex
// [RULE8] Opcode 19 type selects ten operations
// [RULE9] Ops 5-7 bitwise; op 8 inverts accumulator
// [RULE10] Operand is the four value bytes
// [RULE11] Result written back to accumulator
// [RULE12] Arithmetic reply status 100, value undefined
// [RULE13] Operands are 32-bit two's complement
// [RULE14] Compare sets flags, accumulator unchanged
// [RULE15] Host sends compare only in standalone programs
// [RULE16] Standalone input read loads accumulator; direct not
// [RULE17] Jump conditions zero..lower-equal from flags
// [RULE18] Checksum is byte sum; bad frames rejected
// [RULE19] Divide or modulo by zero keeps accumulator
`ifndef ACIOU_CFG_SVH
`define ACIOU_CFG_SVH
`define ACIOU_FRAME_LEN     9
`define ACIOU_OP_INPUT_READ 8'h0f
`define ACIOU_OP_ACC        8'h13
`define ACIOU_OP_COMPARE    8'h14
`define ACIOU_ST_OK         8'h64
`define ACIOU_ST_BAD_SUM    8'h01
`define ACIOU_ST_BAD_CMD    8'h02
`define ACIOU_ST_BAD_TYPE   8'h03
`define ACIOU_ST_BAD_VALUE  8'h04
`define ACIOU_BANK_DIG      8'h00
`define ACIOU_BANK_ANA      8'h01
`define ACIOU_BANK_OUT      8'h02
`define ACIOU_PORT_ALL      8'hff
`define ACIOU_DIG_MAX       8'h06
`define ACIOU_OUT_MAX       8'h07
`define ACIOU_ACC_RST       32'h0000_0000
`endif

/* File: common/aciou_pkg.sv */
// Purpose: Types for the accumulator and I/O command unit
// Assumes: Included constants header
// Notes:   Accumulator operation codes and states
package aciou_pkg;
  typedef enum logic [3:0] {
    ACIOU_ADD = 4'h0, ACIOU_SUB = 4'h1, ACIOU_MUL = 4'h2,
    ACIOU_DIV = 4'h3, ACIOU_MOD = 4'h4, ACIOU_AND = 4'h5,
    ACIOU_OR  = 4'h6, ACIOU_XOR = 4'h7, ACIOU_NOT = 4'h8,
    ACIOU_LOAD = 4'h9
  } aciou_op_e;
  typedef enum logic [1:0] {
    ACIOU_RX   = 2'b00,
    ACIOU_EXEC = 2'b01,
    ACIOU_TX   = 2'b11
  } aciou_state_e;
  typedef logic [31:0] aciou_word_t;
endpackage : aciou_pkg

/* File: hw/aciou_core.sv */
// Purpose: Executes input-read, accumulator and compare commands
// Assumes: Frames arrive a byte per strobe, inputs synchronous
// Notes:   Replies leave a byte per cycle while ready is high
`timescale 1ns/1ps
`include "aciou_cfg.svh"
module aciou_core
  import aciou_pkg::*;
#(
  parameter int ADC_W = 16
)(
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST_N,
  input  wire logic                  RX_VALID,
  input  wire logic [7:0]            RX_BYTE,
  input  wire logic                  STANDALONE,
  input  wire logic [7:0]            HOST_ADDR,
  input  wire logic [6:0]            GP_INPUTS,
  input  wire logic [ADC_W-1:0]      ANALOG_VALUE,
  input  wire logic [7:0]            OUT_LATCH,
  input  wire logic [2:0]            JUMP_COND,
  output logic                       JUMP_TAKE,
  output logic                       TX_VALID,
  input  wire logic                  TX_READY,
  output logic [7:0]                 TX_BYTE,
  output aciou_pkg::aciou_word_t     ACC_VALUE,
  output logic [3:0]                 FLAGS
);
  import aciou_pkg::*;

  // Sum of bytes, shared by check and reply generation
  function automatic logic [7:0] sum8(input logic [7:0] b [0:7]);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = s + b[i];
    return s;
  endfunction : sum8

  ////////////////////////////////////////////////////////////////////////
  aciou_state_e state_q;
  logic [7:0]   rx_q [0:7];
  logic [3:0]   rx_cnt_q;
  logic [7:0]   tx_q [0:7];
  logic [3:0]   tx_cnt_q;
  aciou_word_t  acc_q;
  logic         zero_q, eq_q, gt_q, lt_q;

  wire logic [7:0] opc  = rx_q[1];
  wire logic [7:0] typ  = rx_q[2];
  wire logic [7:0] bank = rx_q[3];
  // Value bytes arrive most significant first  // see [RULE6] [RULE10]
  wire aciou_word_t opnd = {rx_q[4], rx_q[5], rx_q[6], rx_q[7]};
  wire logic       last_rx = RX_VALID && rx_cnt_q == 4'd8;
  logic            sum_ok_q;  // Checksum verdict of the last frame

  // Frame reception; bytes outside RX state are dropped
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      rx_cnt_q <= 4'd0;
    else if (state_q == ACIOU_RX && RX_VALID)
    begin
      if (rx_cnt_q == 4'd8)
      begin
        // Judged as the checksum byte passes; the line moves on at once
        sum_ok_q <= sum8(rx_q) == RX_BYTE;             // see [RULE18]
        rx_cnt_q <= 4'd0;
      end
      else
      begin
        rx_q[rx_cnt_q[2:0]] <= RX_BYTE;
        rx_cnt_q <= rx_cnt_q + 4'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fetched value for an input read, and its validity
  aciou_word_t rd_val;
  logic        rd_ok;
  always_comb
  begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    if (bank == `ACIOU_BANK_DIG && typ == `ACIOU_PORT_ALL)
      rd_val = {25'h0, GP_INPUTS};                     // see [RULE2]
    else if (bank == `ACIOU_BANK_DIG && typ <= `ACIOU_DIG_MAX)
      rd_val = {31'h0, GP_INPUTS[typ[2:0]]};           // see [RULE1] [RULE4]
    else if (bank == `ACIOU_BANK_ANA && typ == 8'h00)
      rd_val = {{(32-ADC_W){1'b0}}, ANALOG_VALUE};     // see [RULE3] [RULE4]
    else if (bank == `ACIOU_BANK_OUT && typ <= `ACIOU_OUT_MAX)
      rd_val = {31'h0, OUT_LATCH[typ[2:0]]};           // see [RULE5]
    else
      rd_ok = 1'b0;
  end

  // Accumulator operation result, signed 32-bit
  aciou_word_t accumulator_op_cmd;
  logic        accumulator_op_cmd_ok;
  always_comb
  begin
    accumulator_op_cmd    = acc_q;
    accumulator_op_cmd_ok = 1'b1;
    unique case (typ[3:0])                             // see [RULE8]
      ACIOU_ADD:  accumulator_op_cmd = acc_q + opnd;                 // see [RULE13]
      ACIOU_SUB:  accumulator_op_cmd = acc_q - opnd;
      ACIOU_MUL:  accumulator_op_cmd = 32'($signed(acc_q) * $signed(opnd));
      // Zero divisor keeps the accumulator, never X  // see [RULE19]
      ACIOU_DIV:  if (opnd != 32'h0) accumulator_op_cmd = $signed(acc_q) / $signed(opnd);
      ACIOU_MOD:  if (opnd != 32'h0) accumulator_op_cmd = $signed(acc_q) % $signed(opnd);
      ACIOU_AND:  accumulator_op_cmd = acc_q & opnd;                 // see [RULE9]
      ACIOU_OR:   accumulator_op_cmd = acc_q | opnd;
      ACIOU_XOR:  accumulator_op_cmd = acc_q ^ opnd;
      ACIOU_NOT:  accumulator_op_cmd = ~acc_q;
      ACIOU_LOAD: accumulator_op_cmd = opnd;
      default:    accumulator_op_cmd_ok = 1'b0;
    endcase
    if (typ[7:4] != 4'h0)
      accumulator_op_cmd_ok = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Execute: pick status and value, update accumulator
  logic [7:0]  st;
  aciou_word_t rv;
  always_comb
  begin
    st = `ACIOU_ST_OK;                                 // see [RULE7] [RULE12]
    rv = opnd;
    if (!sum_ok_q)
      st = `ACIOU_ST_BAD_SUM;                          // see [RULE18]
    else if (opc == `ACIOU_OP_INPUT_READ)
    begin
      rv = rd_val;
      if (!rd_ok) st = `ACIOU_ST_BAD_VALUE;
    end
    else if (opc == `ACIOU_OP_ACC)
    begin
      if (!accumulator_op_cmd_ok) st = `ACIOU_ST_BAD_TYPE;
    end
    else if (opc != `ACIOU_OP_COMPARE)
      st = `ACIOU_ST_BAD_CMD;
  end

  wire logic exec = state_q == ACIOU_EXEC;
  wire logic good = exec && st == `ACIOU_ST_OK;

  // Accumulator write-back
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      acc_q <= `ACIOU_ACC_RST;
    else if (good && opc == `ACIOU_OP_ACC)
      acc_q <= accumulator_op_cmd;                                   // see [RULE11]
    else if (good && opc == `ACIOU_OP_INPUT_READ && STANDALONE)
      acc_q <= rd_val;                                 // see [RULE16] [RULE2]
  end

  // Compare flags; accumulator is not touched here  // see [RULE14]
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      {zero_q, eq_q, gt_q, lt_q} <= 4'h0;
    else if (good && opc == `ACIOU_OP_COMPARE)
    begin
      zero_q <= acc_q == 32'h0;
      eq_q   <= acc_q == opnd;
      gt_q   <= $signed(acc_q) > $signed(opnd);
      lt_q   <= $signed(acc_q) < $signed(opnd);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and reply bytes, host address first
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      state_q  <= ACIOU_RX;
      tx_cnt_q <= 4'd0;
    end
    else unique case (state_q)
      ACIOU_RX:
        if (last_rx) state_q <= ACIOU_EXEC;
      ACIOU_EXEC:
      begin
        tx_q[0] <= HOST_ADDR;                          // see [RULE7]
        tx_q[1] <= rx_q[0];
        tx_q[2] <= st;
        tx_q[3] <= opc;
        {tx_q[4], tx_q[5], tx_q[6], tx_q[7]} <= rv;
        tx_cnt_q <= 4'd0;
        state_q  <= ACIOU_TX;
      end
      ACIOU_TX:
        if (TX_READY)
        begin
          if (tx_cnt_q == 4'd8) state_q <= ACIOU_RX;
          tx_cnt_q <= tx_cnt_q + 4'd1;
        end
      default: state_q <= ACIOU_RX;
    endcase
  end

  // Reply checksum is computed over the stored bytes
  always_comb
  begin
    TX_VALID = state_q == ACIOU_TX;
    TX_BYTE  = tx_cnt_q == 4'd8 ? sum8(tx_q) : tx_q[tx_cnt_q[2:0]];
  end

  // Jump condition decode from flags  // see [RULE17]
  always_comb
  begin
    unique case (JUMP_COND)
      3'd0: JUMP_TAKE = zero_q;
      3'd1: JUMP_TAKE = !zero_q;
      3'd2: JUMP_TAKE = eq_q;
      3'd3: JUMP_TAKE = !eq_q;
      3'd4: JUMP_TAKE = gt_q;
      3'd5: JUMP_TAKE = gt_q || eq_q;
      3'd6: JUMP_TAKE = lt_q;
      3'd7: JUMP_TAKE = lt_q || eq_q;
    endcase
  end

  assign ACC_VALUE = acc_q;
  assign FLAGS     = {zero_q, eq_q, gt_q, lt_q};

  ////////////////////////////////////////////////////////////////////////
  property p_direct_keeps_acc;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (exec && opc == `ACIOU_OP_INPUT_READ && !STANDALONE) |=> $stable(acc_q);
  endproperty
  a_direct_keeps_acc: assert property (p_direct_keeps_acc) // see [RULE16]
    else $error("Direct input read changed accumulator");

  property p_cmp_keeps_acc;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (exec && opc == `ACIOU_OP_COMPARE) |=> $stable(acc_q);
  endproperty
  a_cmp_keeps_acc: assert property (p_cmp_keeps_acc) // see [RULE14]
    else $error("Compare changed accumulator");

  property p_div0;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (exec && opc == `ACIOU_OP_ACC && opnd == 32'h0 &&
       (typ == 8'h3 || typ == 8'h4)) |=> $stable(acc_q);
  endproperty
  a_div0: assert property (p_div0) // see [RULE19]
    else $error("Zero divisor changed accumulator");

  property p_load;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (good && opc == `ACIOU_OP_ACC && typ == 8'h9) |=> acc_q == $past(opnd);
  endproperty
  a_load: assert property (p_load) // see [RULE8]
    else $error("Load did not place operand");

  property p_not;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (good && opc == `ACIOU_OP_ACC && typ == 8'h8) |=> acc_q == ~$past(acc_q);
  endproperty
  a_not: assert property (p_not) // see [RULE9]
    else $error("Invert wrong");

  property p_add;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (good && opc == `ACIOU_OP_ACC && typ == 8'h0)
        |=> acc_q == $past(acc_q) + $past(opnd);
  endproperty
  a_add: assert property (p_add) // see [RULE11]
    else $error("Add result not stored");

  property p_all_inputs;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (good && STANDALONE && opc == `ACIOU_OP_INPUT_READ &&
       bank == 8'h0 && typ == 8'hff) |=> acc_q == {25'h0, $past(GP_INPUTS)};
  endproperty
  a_all_inputs: assert property (p_all_inputs) // see [RULE2]
    else $error("Input sample not in accumulator");

  property p_reply_ok;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (good) |=> ##1 (TX_VALID && tx_q[2] == 8'h64);
  endproperty
  a_reply_ok: assert property (p_reply_ok) // see [RULE7]
    else $error("Good command lacks status 64");

  property p_bad_sum;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (exec && !sum_ok_q) |=> $stable(acc_q) && tx_q[2] == 8'h01;
  endproperty
  a_bad_sum: assert property (p_bad_sum) // see [RULE18]
    else $error("Bad checksum frame executed");

  c_accumulator_op_cmd:  cover property (@(posedge CORE_CLK) good && opc == 8'h13);
  c_cmp:   cover property (@(posedge CORE_CLK) good && opc == 8'h14);
  c_ana:   cover property (@(posedge CORE_CLK) good && bank == 8'h1);
  c_bad:   cover property (@(posedge CORE_CLK) exec && !sum_ok_q);
endmodule : aciou_core

/* File: testbench/aciou_host.sv */
// Purpose: Host model sending command frames and taking replies
// Assumes: Driven on falling edges of the core clock
// Notes:   With slow set it accepts reply bytes on alternate cycles
`timescale 1ns/1ps
module aciou_host (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready
);
  logic [7:0] rep [9];
  int         n;
  bit         slow;
  ////////////////////////////////////////
  // Quiet link at time zero
  initial
  begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_ready = 1'b1;
    slow     = 1'b0;
    n        = 0;
  end
  // Stalling host stretches the reply to catch a design that drops bytes
  always @(negedge clk) tx_ready <= !slow || !tx_ready;
  // Reply bytes kept in arrival order
  always @(posedge clk)
    if (tx_valid && tx_ready && n < 9)
    begin
      rep[n] <= tx_byte;
      n      <= n + 1;
    end
  // Frame bytes leave back to back
  task automatic send(input logic [7:0] f [9]);
    n = 0;
    for (int i = 0; i < 9; i++)
    begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte  = f[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte  = ~f[8]; // Released line shows no stale byte
  endtask : send
endmodule : aciou_host

/* File: testbench/accumulator_io_command_unit_tb.sv */
// Purpose: Self-checking bench for the command unit
// Assumes: Host model drives the frame link on falling edges
// Notes:   Accumulator results are modelled here from the op codes
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, e); end end
module accumulator_io_command_unit_tb;
  import aciou_pkg::*;
  logic        clk, rst_n, sa, rxv, txv, txr, jt;
  logic [7:0]  rxb, txb, ol, st;
  logic [6:0]  gp;
  logic [15:0] ana;
  logic [2:0]  jc;
  logic [3:0]  fl;
  aciou_word_t acc, rv;
  int          fails, tests_run;
  ////////////////////////////////////////
  aciou_core #(.ADC_W(16)) dut (.CORE_CLK(clk), .RST_N(rst_n),
    .RX_VALID(rxv), .RX_BYTE(rxb), .STANDALONE(sa), .HOST_ADDR(8'h02),
    .GP_INPUTS(gp), .ANALOG_VALUE(ana), .OUT_LATCH(ol), .JUMP_COND(jc),
    .JUMP_TAKE(jt), .TX_VALID(txv), .TX_READY(txr), .TX_BYTE(txb),
    .ACC_VALUE(acc), .FLAGS(fl));
  aciou_host host (.clk(clk), .rx_valid(rxv), .rx_byte(rxb),
    .tx_valid(txv), .tx_byte(txb), .tx_ready(txr));
  // One command and its whole reply; checks the reply framing
  task automatic xfer(input logic [7:0] op, ty, bk, input aciou_word_t v,
                      input bit bad);
    logic [7:0] f [9];
    logic [7:0] s;
    logic [23:0] hd;
    int         k;
    f = '{8'h01, op, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    s = 8'h00;
    for (k = 0; k < 8; k++) s += f[k];
    f[8] = bad ? ~s : s;
    host.send(f);
    for (k = 0; k < 300 && host.n < 9; k++) @(negedge clk);
    s = 8'h00;
    for (k = 0; k < 8; k++) s += host.rep[k];
    hd = {host.rep[0], host.rep[1], host.rep[3]};
    `CHK(host.n, 9)
    `CHK(hd, {8'h02, 8'h01, op})
    `CHK(host.rep[8], s)
    st = host.rep[2];
    rv = {host.rep[4], host.rep[5], host.rep[6], host.rep[7]};
    @(negedge clk);
  endtask : xfer
  // Accumulator model; zero divisor keeps the old value
  function automatic aciou_word_t accumulator_op_cmd(input logic [3:0] o,
                                       input aciou_word_t a, b);
    case (o)
      4'h0: return a + b;
      4'h1: return a - b;
      4'h2: return a * b;
      4'h3: if (b != 0) return $signed(a) / $signed(b);
      4'h4: if (b != 0) return $signed(a) % $signed(b);
      4'h5: return a & b;
      4'h6: return a | b;
      4'h7: return a ^ b;
      4'h8: return ~a;
      4'h9: return b;
      default: return a;
    endcase
    return a;
  endfunction : accumulator_op_cmd
  // Direct reads: digital view, analog view of the same line
  task automatic t_inputs;
    sa  = 1'b0;
    gp  = 7'h53;
    ana = 16'h012e;
    for (int p = 0; p < 7; p++)
    begin
      xfer(8'h0f, p[7:0], 8'h00, 32'h0, 1'b0);
      `CHK({st, rv}, {8'h64, 31'h0, gp[p]})
    end
    xfer(8'h0f, 8'h00, 8'h01, 32'h0, 1'b0);
    `CHK(rv, 32'h0000_012e)
    xfer(8'h0f, 8'h00, 8'h00, 32'h0, 1'b0);
    `CHK(rv, {31'h0, gp[0]})
    `CHK(acc, 32'h0)
  endtask : t_inputs
  // Readback of every output latch
  task automatic t_outputs;
    ol = 8'hb5;
    for (int p = 0; p < 8; p++)
    begin
      xfer(8'h0f, p[7:0], 8'h02, 32'h0, 1'b0);
      `CHK(rv, {31'h0, ol[p]})
    end
  endtask : t_outputs
  // Stored-program reads land in the accumulator; bad sum is refused
  task automatic t_standalone;
    sa = 1'b1;
    gp = 7'h2c;
    xfer(8'h0f, 8'hff, 8'h00, 32'h0, 1'b0);
    `CHK(acc, {25'h0, gp})
    xfer(8'h0f, 8'h00, 8'h01, 32'h0, 1'b0);
    `CHK(acc, 32'h0000_012e)
    xfer(8'h13, 8'h09, 8'h00, 32'h5, 1'b1);
    `CHK({st, acc}, {8'h01, 32'h0000_012e})
  endtask : t_standalone
  // Every operation in turn, host stalling the replies
  task automatic t_accumulator_op_cmd;
    logic [3:0]  o [12] = '{9, 0, 1, 2, 3, 4, 5, 6, 7, 8, 3, 4};
    aciou_word_t v [12] = '{1000, 32'hffffec78, 7, 32'hffffec78, 7,
                            1000, 32'hf0, 32'h0f, 32'hff,
                            0, 0, 0};
    aciou_word_t e;
    sa        = 1'b0;
    host.slow = 1'b1;
    e         = 32'h0;
    for (int i = 0; i < 12; i++)
    begin
      e = accumulator_op_cmd(o[i], e, v[i]);
      xfer(8'h13, {4'h0, o[i]}, 8'h00, v[i], 1'b0);
      `CHK({st, acc}, {8'h64, e})
    end
    host.slow = 1'b0;
  endtask : t_accumulator_op_cmd
  // Equal, lower and greater compares against -113, all jump codes,
  // then a zero accumulator so the zero flag is seen set as well
  task automatic t_compare;
    aciou_word_t v [3]  = '{32'hffffff8f, 32'h0, 32'hffffff38};
    logic [7:0]  tk [3] = '{8'ha6, 8'hca, 8'h3a};
    logic [3:0]  fx [3] = '{4'h4, 4'h1, 4'h2};
    sa = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      xfer(8'h14, 8'h00, 8'h00, v[i], 1'b0);
      `CHK({st, fl, acc}, {8'h64, fx[i], 32'hffffff8f})
      for (int c = 0; c < 8; c++)
      begin
        @(negedge clk);
        jc = c[2:0];
        #1;
        `CHK(jt, tk[i][c])
      end
    end
    xfer(8'h13, 8'h09, 8'h00, 32'h0, 1'b0);
    xfer(8'h14, 8'h00, 8'h00, 32'h0, 1'b0);
    `CHK({fl, acc}, {4'hc, 32'h0})
    @(negedge clk);
    jc = 3'd0;
    #1;
    `CHK(jt, 1'b1)
  endtask : t_compare
  // Verdict
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Reset, then the scenarios
  initial
  begin
    {rst_n, sa, gp, ana, ol, jc} = '0;
    fails     = 0;
    tests_run = 0;
    repeat (8) @(negedge clk);
    `CHK({txv, acc, fl}, {1'b0, 32'h0, 4'h0})
    rst_n = 1'b1;
    t_inputs;
    t_outputs;
    t_standalone;
    t_accumulator_op_cmd;
    t_compare;
    summarize;
  end
  // Hang guard far above the fewer than one thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize;
  end
endmodule : accumulator_io_command_unit_tb
